/* design/gpm_port.sv */
// Port I/O block: output latches, pin reads, crossbar skip, pin modes and
// port 1 match. Assumes the core issues one SFR access per cycle on clk.
`include "gpm_cfg.svh"
`default_nettype none

// Function
// - Masked port 1 pins compare against match bits: zero low, one high.
// - Port registers reachable by byte and by single bit.
// - Port write goes to a latch that holds the pin value.
// - Ordinary port read returns pin levels, even crossbar-owned pins.
// - Read-modify-write accesses read the latch, not the pins.
// - Per-pin skip decides whether the crossbar takes the pin.
// - Per-pin analog/digital select, never set by crossbar assignment.
// - Port 2 bit 4 is digital only.
// - Per-pin open-drain or push-pull, not set by crossbar.
// - SMBus pins always open drain.
module gpm_port
    import gpm_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire gpm_sfr_req_t           sfr_req,
    output logic      [7:0]             sfr_rdata,
    output logic                        sfr_rvalid,
    input  wire logic [`GPM_NPIN-1:0]   pin_in,
    input  wire logic [`GPM_NPIN-1:0]   xbar_assign,
    input  wire logic [`GPM_NPIN-1:0]   xbar_data,
    input  wire logic [`GPM_NPIN-1:0]   smbus_pin,
    output logic      [`GPM_NPIN-1:0]   pin_out,
    output logic      [`GPM_NPIN-1:0]   pin_oe_n,
    output logic      [`GPM_NPIN-1:0]   pin_digital_en,
    output logic                        port_match
);

    // ****************************************
    // Address decode
    // ****************************************
    function automatic gpm_idx_t reg_index(input logic [7:0] a);
        gpm_idx_t r;
        r = `GPM_IDX_NONE;
        case (a)
            `GPM_ADDR_PORT0:   r = `GPM_IDX_LATCH0;
            `GPM_ADDR_PORT1:   r = `GPM_IDX_LATCH1;
            `GPM_ADDR_PORT2:   r = `GPM_IDX_LATCH2;
            `GPM_ADDR_SKIP0:   r = `GPM_IDX_SKIP0;
            `GPM_ADDR_SKIP1:   r = `GPM_IDX_SKIP1;
            `GPM_ADDR_SKIP2:   r = `GPM_IDX_SKIP2;
            `GPM_ADDR_MDIN0:   r = `GPM_IDX_MDIN0;
            `GPM_ADDR_MDIN1:   r = `GPM_IDX_MDIN1;
            `GPM_ADDR_MDIN2:   r = `GPM_IDX_MDIN2;
            `GPM_ADDR_MDOUT0:  r = `GPM_IDX_MDOUT0;
            `GPM_ADDR_MDOUT1:  r = `GPM_IDX_MDOUT1;
            `GPM_ADDR_MDOUT2:  r = `GPM_IDX_MDOUT2;
            `GPM_ADDR_P1MATCH: r = `GPM_IDX_P1MATCH;
            `GPM_ADDR_PORT1_MATCH_MASK:  r = `GPM_IDX_PORT1_MATCH_MASK;
            default:           r = `GPM_IDX_NONE;
        endcase
        return r;
    endfunction

    logic [7:0]             regs [0:`GPM_NREG-1];
    logic [7:0]             next_regs [0:`GPM_NREG-1];
    logic [`GPM_NPIN-1:0]   pin_sync;
    gpm_idx_t               byte_idx;
    gpm_idx_t               bit_idx;
    logic [2:0]             bit_sel;
    logic                   bit_port;
    logic [`GPM_NPIN-1:0]   latch_bits;
    logic [`GPM_NPIN-1:0]   skip_bits;
    logic [`GPM_NPIN-1:0]   mdin_bits;
    logic [`GPM_NPIN-1:0]   mdout_bits;
    logic [`GPM_NPIN-1:0]   next_pin_out;
    logic [`GPM_NPIN-1:0]   next_pin_oe_n;
    logic [`GPM_NPIN-1:0]   next_digital_en;
    logic [7:0]             next_rdata;
    logic                   next_rvalid;
    logic                   next_match;

    gpm_sync gpm_sync_i
    (
        .clk     (clk),
        .reset_n (reset_n),
        .d_async (pin_in),
        .q       (pin_sync)
    );

    // Only ports sit on multiples of eight, so only they are bit addressable
    assign byte_idx = reg_index(sfr_req.addr);
    assign bit_idx  = reg_index({sfr_req.addr[7:3], 3'h0});
    assign bit_sel  = sfr_req.addr[2:0];
    assign bit_port = (bit_idx <= `GPM_IDX_LATCH2);

    assign latch_bits = {regs[`GPM_IDX_LATCH2], regs[`GPM_IDX_LATCH1], regs[`GPM_IDX_LATCH0]};
    assign skip_bits  = {regs[`GPM_IDX_SKIP2], regs[`GPM_IDX_SKIP1], regs[`GPM_IDX_SKIP0]};
    assign mdin_bits  = {regs[`GPM_IDX_MDIN2], regs[`GPM_IDX_MDIN1], regs[`GPM_IDX_MDIN0]};
    assign mdout_bits = {regs[`GPM_IDX_MDOUT2], regs[`GPM_IDX_MDOUT1], regs[`GPM_IDX_MDOUT0]};

    // ****************************************
    // Register writes
    // ****************************************
    always_comb
    begin
        for (int i = 0; i < `GPM_NREG; i++)
        begin
            next_regs[i] = regs[i];
        end
        if (sfr_req.wr)
        begin
            if (sfr_req.bit_op)
            begin
                if (bit_port)
                begin
                    next_regs[bit_idx][bit_sel] = sfr_req.bit_val;
                end
            end
            else if (byte_idx != `GPM_IDX_NONE)
            begin
                next_regs[byte_idx] = sfr_req.wdata;
            end
        end
        // No analog option on this pin
        next_regs[`GPM_IDX_MDIN2][`GPM_P2_DIGITAL_BIT] = 1'b1;
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_comb
    begin
        logic [7:0] sel;
        gpm_idx_t   idx;
        sel         = 8'h00;
        idx         = sfr_req.bit_op ? bit_idx : byte_idx;
        next_rvalid = sfr_req.rd;
        if (idx <= `GPM_IDX_LATCH2)
        begin
            // Pins normally; latch when the core will write the byte back
            sel = sfr_req.rmw ? regs[idx] : pin_sync[8*idx +: 8];
        end
        else if (idx != `GPM_IDX_NONE)
        begin
            sel = regs[idx];
        end
        if (!sfr_req.rd)
        begin
            next_rdata = sfr_rdata;
        end
        else if (sfr_req.bit_op)
        begin
            next_rdata = {7'h00, bit_port & sel[bit_sel]};
        end
        else
        begin
            next_rdata = sel;
        end
    end

    // ****************************************
    // Pin drive and mode
    // ****************************************
    for (genvar i = 0; i < `GPM_NPIN; i++)
    begin : g_pin
        logic src;
        logic od;
        // Crossbar only owns pins it has not been told to skip
        assign src = (xbar_assign[i] & ~skip_bits[i]) ? xbar_data[i] : latch_bits[i];
        // SMBus lines are open drain whatever the mode bit says
        assign od  = smbus_pin[i] | ~mdout_bits[i];
        assign next_pin_out[i]    = src;
        assign next_pin_oe_n[i]   = od & src;
        // Mode comes only from the register, never from the crossbar
        assign next_digital_en[i] = mdin_bits[i];
    end

    // ****************************************
    // Port 1 match
    // ****************************************
    assign next_match = |((pin_sync[15:8] ^ regs[`GPM_IDX_P1MATCH]) & regs[`GPM_IDX_PORT1_MATCH_MASK]);

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < `GPM_NPORT; i++)
            begin
                regs[i]                        <= `GPM_RST_LATCH;
                regs[i + `GPM_NPORT]           <= `GPM_RST_SKIP;
                regs[i + 2 * `GPM_NPORT]       <= `GPM_RST_MDIN;
                regs[i + 3 * `GPM_NPORT]       <= `GPM_RST_MDOUT;
            end
            regs[`GPM_IDX_P1MATCH] <= `GPM_RST_P1MATCH;
            regs[`GPM_IDX_PORT1_MATCH_MASK]  <= `GPM_RST_PORT1_MATCH_MASK;
            sfr_rdata              <= 8'h00;
            sfr_rvalid             <= 1'b0;
            pin_out                <= '1;
            pin_oe_n               <= '1;
            pin_digital_en         <= '1;
            port_match             <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < `GPM_NREG; i++)
            begin
                regs[i] <= next_regs[i];
            end
            sfr_rdata      <= next_rdata;
            sfr_rvalid     <= next_rvalid;
            pin_out        <= next_pin_out;
            pin_oe_n       <= next_pin_oe_n;
            pin_digital_en <= next_digital_en;
            port_match     <= next_match;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_match_compare: assert property (
        $past(reset_n) |-> port_match ==
            $past((pin_sync[15:8] & regs[`GPM_IDX_PORT1_MATCH_MASK]) !=
                  (regs[`GPM_IDX_P1MATCH] & regs[`GPM_IDX_PORT1_MATCH_MASK])))
        else $error("Port match flag disagrees with masked compare");

    a_match_event: assert property (
        (regs[`GPM_IDX_PORT1_MATCH_MASK] == 8'h00) |=> !port_match)
        else $error("Match event with an empty mask");

    a_byte_latch: assert property (
        (sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == `GPM_ADDR_PORT1 &&
         xbar_assign[15:8] == 8'h00) ##1 (xbar_assign[15:8] == 8'h00)
        |=> pin_out[15:8] == $past(sfr_req.wdata, 2))
        else $error("Port 1 latch did not reach the pins");

    a_bit_write: assert property (
        (sfr_req.wr && sfr_req.bit_op && sfr_req.addr[7:3] == 5'h10)
        |=> regs[`GPM_IDX_LATCH0][$past(sfr_req.addr[2:0])] == $past(sfr_req.bit_val))
        else $error("Bit write to port 0 lost");

    a_pin_read: assert property (
        (sfr_req.rd && !sfr_req.rmw && !sfr_req.bit_op && sfr_req.addr == `GPM_ADDR_PORT1)
        |=> sfr_rvalid && sfr_rdata == $past(pin_sync[15:8]))
        else $error("Port read did not return pin levels");

    a_rmw_read: assert property (
        (sfr_req.rd && sfr_req.rmw && !sfr_req.bit_op && sfr_req.addr == `GPM_ADDR_PORT2)
        |=> sfr_rdata == $past(regs[`GPM_IDX_LATCH2]))
        else $error("Read-modify-write did not read the latch");

    a_skip_pass: assert property (
        skip_bits[0] |=> pin_out[0] == $past(latch_bits[0]))
        else $error("Skipped pin taken by the crossbar");

    a_mdin_write: assert property (
        (sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == `GPM_ADDR_MDIN0)
        |=> ##1 pin_digital_en[7:0] == $past(sfr_req.wdata, 2))
        else $error("Input mode not taken from register");

    a_p24_digital: assert property (
        $past(reset_n) |-> pin_digital_en[16 + `GPM_P2_DIGITAL_BIT])
        else $error("Port 2 bit 4 left digital mode");

    a_push_pull: assert property (
        (mdout_bits[0] && !smbus_pin[0]) |=> !pin_oe_n[0])
        else $error("Push-pull pin not driven");

    a_smbus_od: assert property (
        $past(reset_n) |-> (pin_out & ~pin_oe_n & $past(smbus_pin)) == '0)
        else $error("SMBus pin driven high");

endmodule

`default_nettype wire

/* common/gpm_cfg.svh */
// Constants for the port access and match block: SFR addresses, storage
// indexes, reset values and widths. Assumes an 8-bit SFR space.
`ifndef GPM_CFG_SVH
`define GPM_CFG_SVH

// ****************************************
// Sizes
// ****************************************
`define GPM_NPORT           3
`define GPM_NPIN            24
`define GPM_NREG            14

// ****************************************
// SFR byte addresses
// ****************************************
`define GPM_ADDR_PORT0      8'h80
`define GPM_ADDR_PORT1      8'h90
`define GPM_ADDR_PORT2      8'ha0
`define GPM_ADDR_SKIP0      8'hd4
`define GPM_ADDR_SKIP1      8'hd5
`define GPM_ADDR_SKIP2      8'hd6
`define GPM_ADDR_MDIN0      8'hf1
`define GPM_ADDR_MDIN1      8'hf2
`define GPM_ADDR_MDIN2      8'hf3
`define GPM_ADDR_MDOUT0     8'ha4
`define GPM_ADDR_MDOUT1     8'ha5
`define GPM_ADDR_MDOUT2     8'ha6
`define GPM_ADDR_P1MATCH    8'hed
`define GPM_ADDR_PORT1_MATCH_MASK     8'hee

// ****************************************
// Storage indexes
// ****************************************
`define GPM_IDX_LATCH0      4'h0
`define GPM_IDX_LATCH1      4'h1
`define GPM_IDX_LATCH2      4'h2
`define GPM_IDX_SKIP0       4'h3
`define GPM_IDX_SKIP1       4'h4
`define GPM_IDX_SKIP2       4'h5
`define GPM_IDX_MDIN0       4'h6
`define GPM_IDX_MDIN1       4'h7
`define GPM_IDX_MDIN2       4'h8
`define GPM_IDX_MDOUT0      4'h9
`define GPM_IDX_MDOUT1      4'ha
`define GPM_IDX_MDOUT2      4'hb
`define GPM_IDX_P1MATCH     4'hc
`define GPM_IDX_PORT1_MATCH_MASK      4'hd
`define GPM_IDX_NONE        4'hf

// ****************************************
// Reset values and fixed fields
// ****************************************
`define GPM_RST_LATCH       8'hff
`define GPM_RST_SKIP        8'h00
`define GPM_RST_MDIN        8'hff
`define GPM_RST_MDOUT       8'h00
`define GPM_RST_P1MATCH     8'hff
`define GPM_RST_PORT1_MATCH_MASK      8'h00
`define GPM_P2_DIGITAL_BIT  4

`endif

/* common/gpm_pkg.sv */
// Types shared by the port access and match block.
// Assumes gpm_cfg.svh is on the include path.
`include "gpm_cfg.svh"
`default_nettype none

package gpm_pkg;

    typedef logic [3:0] gpm_idx_t;

    // One SFR access from the core; bit_op uses addr as a bit address
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       rmw;
        logic       bit_op;
        logic       bit_val;
    } gpm_sfr_req_t;

endpackage

`default_nettype wire

/* design/gpm_sync.sv */
// Two-flop synchroniser for all port pin inputs.
// Assumes pins are asynchronous to clk; reset is synchronous.
`include "gpm_cfg.svh"
`default_nettype none

module gpm_sync
    import gpm_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic [`GPM_NPIN-1:0]   d_async,
    output logic      [`GPM_NPIN-1:0]   q
);

    logic [`GPM_NPIN-1:0] meta;
    logic [`GPM_NPIN-1:0] next_meta;
    logic [`GPM_NPIN-1:0] next_q;

    always_comb
    begin
        next_meta = d_async;
        next_q    = meta;
    end

    // First stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= next_meta;
            q    <= next_q;
        end
    end

endmodule

`default_nettype wire

/* testbench/gpm_pin_model.sv */
// Stand-in for the pins and the far-side drivers of the port block.
// Assumes the bench sets which pins an outside part pulls and to what level.
`include "gpm_cfg.svh"
`default_nettype none

module gpm_pin_model
(
    input  wire logic [`GPM_NPIN-1:0] pin_out,
    input  wire logic [`GPM_NPIN-1:0] pin_oe_n,
    input  wire logic [`GPM_NPIN-1:0] ext_en,
    input  wire logic [`GPM_NPIN-1:0] ext_level,
    output logic      [`GPM_NPIN-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Wired-AND with pull-up, so a released pin reads high, never stale
    always_comb
    begin
        pin_in = (pin_out | pin_oe_n) & (~ext_en | ext_level);
    end
endmodule

`default_nettype wire

/* testbench/gpm_port_bench.sv */
// Self-checking bench for the port block: SFR accesses, pin drive, match.
// Assumes the pin model closes the loop from pin_out back to pin_in.
`include "gpm_cfg.svh"
`default_nettype none

module gpm_port_bench;
    import gpm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 clk;
    logic                 reset_n;
    gpm_sfr_req_t         req;
    logic [7:0]           sfr_rdata;
    logic                 sfr_rvalid;
    logic [`GPM_NPIN-1:0] pin_in, pin_out, pin_oe_n, pin_digital_en;
    logic [`GPM_NPIN-1:0] xa, xd, smb, ext_en, ext_lv;
    logic                 port_match;
    int                   error_cnt, comparisons, cycles;

    gpm_port gpm_port_i (.clk(clk), .reset_n(reset_n), .sfr_req(req),
        .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .pin_in(pin_in),
        .xbar_assign(xa), .xbar_data(xd), .smbus_pin(smb), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_digital_en(pin_digital_en), .port_match(port_match));

    gpm_pin_model gpm_pin_model_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_en(ext_en), .ext_level(ext_lv), .pin_in(pin_in));

    // ****************************************
    // Clock, watchdog, report
    // ****************************************
    initial clk = 1'b0;
    always #20 clk = ~clk;

    task automatic test_done();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Whole run needs well under 1000 cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ****************************************
    // SFR access tasks
    // ****************************************
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w, r, m, b, v);
        gpm_sfr_req_t q;
        q = '{addr: a, wdata: d, wr: w, rd: r, rmw: m, bit_op: b, bit_val: v};
        @(posedge clk);
        req <= q;
        @(posedge clk);
        req <= '0;
        #1;
        if (r)
            chk("rvalid", 24'h1, {23'h0, sfr_rvalid});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, d, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e, input string n);
        acc(a, 8'h00, 1'b0, 1'b1, m, 1'b0, 1'b0);
        chk(n, {16'h0, e}, {16'h0, sfr_rdata});
    endtask

    task automatic rdb(input logic [7:0] a, input logic m, input logic e, input string n);
        acc(a, 8'h00, 1'b0, 1'b1, m, 1'b1, 1'b0);
        chk(n, {16'h0, 7'h0, e}, {16'h0, sfr_rdata});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        error_cnt = 0;
        comparisons = 0;
        cycles = 0;
        req = '0;
        xa = '0;
        xd = '0;
        smb = '0;
        ext_en = '0;
        ext_lv = '0;
        reset_n = 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("pin_out rst", 24'hffffff, pin_out);
        chk("oe_n rst", 24'hffffff, pin_oe_n);
        chk("digital rst", 24'hffffff, pin_digital_en);
        chk("match flag rst", 24'h0, {23'h0, port_match});
        rd(`GPM_ADDR_P1MATCH, 1'b0, 8'hff, "match value rst");
        rd(`GPM_ADDR_PORT1_MATCH_MASK, 1'b0, 8'h00, "mask rst");
        rd(`GPM_ADDR_PORT0, 1'b1, 8'hff, "latch rst");
        // Unmapped byte: write ignored, read zero
        wr(8'h81, 8'hff);
        rd(8'h81, 1'b0, 8'h00, "unmapped");
        // P0 as plain push-pull GPIO
        wr(`GPM_ADDR_SKIP0, 8'hff);
        wr(`GPM_ADDR_MDOUT0, 8'hff);
        wr(`GPM_ADDR_PORT0, 8'h5a);
        tick(2);
        chk("p0 out", 24'h5a, {16'h0, pin_out[7:0]});
        chk("p0 oe_n", 24'h0, {16'h0, pin_oe_n[7:0]});
        tick(3);
        rd(`GPM_ADDR_PORT0, 1'b0, 8'h5a, "p0 pins");
        // P1 still open drain: high bits released, pull-up reads them high
        wr(`GPM_ADDR_PORT1, 8'ha5);
        tick(5);
        chk("p1 latch out", 24'ha5, {16'h0, pin_out[15:8]});
        chk("p1 od oe_n", 24'ha5, {16'h0, pin_oe_n[15:8]});
        rd(`GPM_ADDR_PORT1, 1'b0, 8'ha5, "p1 pins");
        acc(8'h80, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        acc(8'h81, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        // Outside part pulls P0.3 low: pins and latch now differ
        @(posedge clk);
        ext_en[3] <= 1'b1;
        tick(5);
        rd(`GPM_ADDR_PORT0, 1'b0, 8'h51, "p0 pins pulled");
        rd(`GPM_ADDR_PORT0, 1'b1, 8'h59, "p0 latch");
        rdb(8'h83, 1'b1, 1'b1, "p0.3 latch bit");
        rdb(8'h83, 1'b0, 1'b0, "p0.3 pin bit");
        @(posedge clk);
        ext_en[3] <= 1'b0;
        smb[7:0] <= 8'h03;
        tick(2);
        chk("smbus oe_n", 24'h01, {16'h0, pin_oe_n[7:0]});
        @(posedge clk);
        smb <= '0;
        // Skipped pins ignore the crossbar; input mode never follows it
        wr(`GPM_ADDR_MDIN0, 8'h0f);
        @(posedge clk);
        xa[7:0] <= 8'hff;
        tick(2);
        chk("p0 digital", 24'h0f, {16'h0, pin_digital_en[7:0]});
        chk("p0 skip", 24'h59, {16'h0, pin_out[7:0]});
        @(posedge clk);
        xa[7:0] <= 8'h00;
        wr(`GPM_ADDR_MDIN2, 8'h00);
        rd(`GPM_ADDR_MDIN2, 1'b0, 8'h10, "mdin2");
        tick(1);
        chk("p2 digital", 24'h10, {16'h0, pin_digital_en[23:16]});
        // P2 handed to the crossbar
        wr(`GPM_ADDR_MDOUT2, 8'hff);
        @(posedge clk);
        xa[23:16] <= 8'hff;
        xd[23:16] <= 8'h3c;
        tick(2);
        chk("p2 xbar out", 24'h3c, {16'h0, pin_out[23:16]});
        tick(3);
        rd(`GPM_ADDR_PORT2, 1'b0, 8'h3c, "p2 pins");
        rd(`GPM_ADDR_PORT2, 1'b1, 8'hff, "p2 latch");
        wr(`GPM_ADDR_SKIP2, 8'hff);
        tick(2);
        chk("p2 skipped", 24'hff, {16'h0, pin_out[23:16]});
        // P1 crossbar-driven, still open drain until told otherwise
        @(posedge clk);
        xa[15:8] <= 8'hff;
        xd[15:8] <= 8'h0f;
        tick(2);
        chk("p1 open drain", 24'h0f, {16'h0, pin_oe_n[15:8]});
        wr(`GPM_ADDR_MDOUT1, 8'hff);
        tick(2);
        chk("p1 push-pull", 24'h00, {16'h0, pin_oe_n[15:8]});
        tick(3);
        wr(`GPM_ADDR_P1MATCH, 8'h00);
        tick(2);
        chk("unmasked", 24'h0, {23'h0, port_match});
        for (int i = 0; i < 8; i++)
        begin
            wr(`GPM_ADDR_PORT1_MATCH_MASK, 8'(8'h01 << i));
            wr(`GPM_ADDR_P1MATCH, 8'(8'h0f ^ (8'h01 << i)));
            tick(2);
            chk("match hit", 24'h1, {23'h0, port_match});
            wr(`GPM_ADDR_P1MATCH, 8'h0f);
            tick(2);
            chk("match quiet", 24'h0, {23'h0, port_match});
        end
        test_done();
    end
endmodule

`default_nettype wire
